// ---- verilog/ppsb_pkg.sv ----
// Package of constants shared by the parallel port pin and buffer status block.
`default_nettype none
package ppsb_pkg;
	// ----------------------------------------------------------------
	// Bus and buffer geometry.
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 2;
	localparam int BUF_BYTES = 4;
	localparam int IRQ_W = 4;

	// ----------------------------------------------------------------
	// Register byte offsets.
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PIN_ENABLE = 8'h00;
	localparam logic [7:0] OFS_BUF_STATUS = 8'h04;
	localparam logic [7:0] OFS_PAD_CFG = 8'h08;
	localparam logic [7:0] OFS_CAL = 8'h0c;
	localparam logic [7:0] OFS_PORT_MODE = 8'h10;
	localparam logic [7:0] OFS_IN_BASE = 8'h20;
	localparam logic [7:0] OFS_OUT_BASE = 8'h30;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h44;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h48;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int PE_CS_BIT = 14;
	localparam int ST_IBF = 15;
	localparam int ST_INPUT_OVERFLOW = 14;
	localparam int ST_IBF_LO = 8;
	localparam int ST_OBE = 7;
	localparam int ST_OUTPUT_UNDERFLOW = 6;
	localparam int PC_CLKSEL = 1;
	localparam int PC_TTL = 0;
	localparam int CAL_CLKOE = 10;
	localparam int MODE_IRQ_LO = 13;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_UNF = 1;
	localparam int IRQ_LAST = 2;
	localparam int IRQ_XFER = 3;

	// ----------------------------------------------------------------
	// Implemented-bit masks and reset values.
	// ----------------------------------------------------------------
	localparam logic [15:0] PE_MASK = 16'h47ff;
	localparam logic [15:0] PC_MASK = 16'h0003;
	localparam logic [15:0] CAL_MASK = 16'h0400;
	localparam logic [15:0] MODE_MASK = 16'h6000;
	localparam logic [15:0] PE_RST = 16'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] CAL_RST = 16'h0000;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [3:0] IN_FULL_RST = 4'h0;
	localparam logic [3:0] OUT_EMPTY_RST = 4'hf;

	// Interrupt request modes, in register encoding order.
	typedef enum logic [1:0] {
		PPSB_IRQ_NONE,
		PPSB_IRQ_XFER,
		PPSB_IRQ_STALL,
		PPSB_IRQ_LAST
	} ppsb_interrupt_mode_select_e;
endpackage : ppsb_pkg
`default_nettype wire

// ---- verilog/ppsb_buf_if.sv ----
// Interface between the register side and the byte buffer bank.
`timescale 1ns/1ps
`default_nettype none
interface ppsb_buf_if;
	logic ext_wr;
	logic ext_rd;
	logic [1:0] ext_idx;
	logic [7:0] ext_wdata;
	logic [7:0] ext_rdata;
	logic sw_rd_in;
	logic sw_wr_out;
	logic [1:0] sw_idx;
	logic [7:0] sw_wdata;
	logic [31:0] in_data;
	logic [3:0] in_full;
	logic [3:0] out_empty;
	logic ovf_evt;
	logic unf_evt;
	logic last_evt;
	logic xfer_evt;

	modport bank (
		input ext_wr, ext_rd, ext_idx, ext_wdata, sw_rd_in, sw_wr_out,
		input sw_idx, sw_wdata,
		output ext_rdata, in_data, in_full, out_empty,
		output ovf_evt, unf_evt, last_evt, xfer_evt
	);
	modport ctl (
		output ext_wr, ext_rd, ext_idx, ext_wdata, sw_rd_in, sw_wr_out,
		output sw_idx, sw_wdata,
		input ext_rdata, in_data, in_full, out_empty,
		input ovf_evt, unf_evt, last_evt, xfer_evt
	);
endinterface : ppsb_buf_if
`default_nettype wire

// ---- verilog/ppsb_bank.sv ----
// Four-byte input and output buffers with their per-byte flags.
`timescale 1ns/1ps
`default_nettype none
module ppsb_bank (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	ppsb_buf_if.bank b
);
	logic [7:0] in_mem_r [4];
	logic [7:0] in_mem_nxt [4];
	logic [7:0] out_mem_r [4];
	logic [7:0] out_mem_nxt [4];
	logic [3:0] in_full_r, in_full_nxt;
	logic [3:0] out_empty_r, out_empty_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	// Events come from the current flags, so a full byte refuses data.
	always_comb begin
		in_mem_nxt = in_mem_r;
		out_mem_nxt = out_mem_r;
		in_full_nxt = in_full_r;
		out_empty_nxt = out_empty_r;
		rdata_nxt = rdata_r;
		b.ovf_evt = 1'b0;
		b.unf_evt = 1'b0;
		// A software read empties its input byte.
		if (b.sw_rd_in) begin
			in_full_nxt[b.sw_idx] = 1'b0;
		end
		// The peer writes input bytes; a full one is kept and flagged.
		if (b.ext_wr) begin
			if (in_full_r[b.ext_idx]) begin
				b.ovf_evt = 1'b1;
			end else begin
				in_mem_nxt[b.ext_idx] = b.ext_wdata;
				in_full_nxt[b.ext_idx] = 1'b1;
			end
		end
		// The peer reads output bytes; an empty one is flagged.
		if (b.ext_rd) begin
			if (out_empty_r[b.ext_idx]) begin
				b.unf_evt = 1'b1;
			end else begin
				rdata_nxt = out_mem_r[b.ext_idx];
				out_empty_nxt[b.ext_idx] = 1'b1; // Transmitted.
			end
		end
		// New software data wins over a transmit of the same byte.
		if (b.sw_wr_out) begin
			out_mem_nxt[b.sw_idx] = b.sw_wdata;
			out_empty_nxt[b.sw_idx] = 1'b0;
		end
		b.last_evt = (b.ext_wr | b.ext_rd) & (&b.ext_idx);
		b.xfer_evt = b.ext_wr | b.ext_rd;
	end

	// Flags and data registers.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			in_full_r <= ppsb_pkg::IN_FULL_RST;
			out_empty_r <= ppsb_pkg::OUT_EMPTY_RST;
			rdata_r <= 8'h00;
			in_mem_r <= '{default: 8'h00};
			out_mem_r <= '{default: 8'h00};
		end else begin
			in_full_r <= in_full_nxt;
			out_empty_r <= out_empty_nxt;
			rdata_r <= rdata_nxt;
			in_mem_r <= in_mem_nxt;
			out_mem_r <= out_mem_nxt;
		end
	end

	assign b.in_full = in_full_r;
	assign b.out_empty = out_empty_r;
	assign b.ext_rdata = rdata_r;
	assign b.in_data = {in_mem_r[3], in_mem_r[2], in_mem_r[1], in_mem_r[0]};

	AST_IN_READ_CLEARS: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		b.sw_rd_in && !b.ext_wr |=> !in_full_r[$past(b.sw_idx)])
		else $error("input byte flag stayed set after software read");
	AST_OUT_WRITE_CLEARS: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		b.sw_wr_out |=> !out_empty_r[$past(b.sw_idx)])
		else $error("output byte still empty after software write");
endmodule : ppsb_bank
`default_nettype wire

// ---- verilog/ppsb_top.sv ----
// Parallel port pad routing, buffer status and interrupt registers.
`timescale 1ns/1ps
`default_nettype none
module ppsb_top #(
	parameter int ADDR_W = ppsb_pkg::ADDR_W
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic ext_wr_i,
	input wire logic ext_rd_i,
	input wire logic [1:0] ext_idx_i,
	input wire logic [7:0] ext_wdata_i,
	output logic [7:0] ext_rdata_o,
	input wire logic [15:0] port_address_pins_i,
	input wire logic [15:0] gpio_out_i,
	input wire logic [15:0] gpio_oe_n_i,
	output logic [15:0] pad_out_o,
	output logic [15:0] pad_oe_n_o,
	input wire logic rtc_second_i,
	input wire logic rtc_alarm_i,
	output logic clock_out_o,
	output logic clock_out_oe_n_o,
	output logic input_threshold_select_o,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// Elaboration check.
	// ----------------------------------------------------------------
	// The decoder compares eight-bit offsets, so a narrower bus cannot work.
	if (ADDR_W < 8) begin : g_bad_addr
		$error("ADDR_W must be at least 8");
	end

	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	logic [15:0] pe_r, pe_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] cal_r, cal_nxt;
	logic [15:0] mode_r, mode_nxt;
	logic ovf_r, ovf_nxt;
	logic unf_r, unf_nxt;
	logic [3:0] irq_stat_r, irq_stat_nxt;
	logic [3:0] irq_en_r, irq_en_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [15:0] pad_out_r, pad_out_nxt;
	logic [15:0] pad_oe_n_r, pad_oe_n_nxt;
	logic clk_out_r, clk_out_nxt;
	logic clk_oe_n_r, clk_oe_n_nxt;
	logic [7:0] addr8;
	logic input_full_summary;
	logic output_empty_summary;
	logic [15:0] status_word;
	ppsb_pkg::ppsb_interrupt_mode_select_e irq_mode;

	ppsb_buf_if bif ();

	// Offset decode for the write path; the read path decodes with a case on addr8.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Byte buffer window: offsets base, base+4, base+8, base+12.
	function automatic logic in_win(input logic [7:0] a,
			input logic [7:0] base);
		in_win = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
	endfunction : in_win

	assign addr8 = reg_addr_i[7:0];
	assign irq_mode = ppsb_pkg::ppsb_interrupt_mode_select_e'(mode_r[ppsb_pkg::MODE_IRQ_LO +: 2]);

	// ----------------------------------------------------------------
	// Buffer bank hookup.
	// ----------------------------------------------------------------
	// Peer strobes go straight through; the bank never stalls them.
	assign bif.ext_wr = ext_wr_i;
	assign bif.ext_rd = ext_rd_i;
	assign bif.ext_idx = ext_idx_i;
	assign bif.ext_wdata = ext_wdata_i;
	assign bif.sw_rd_in = reg_rd_i && in_win(addr8, ppsb_pkg::OFS_IN_BASE);
	assign bif.sw_wr_out = reg_wr_i && in_win(addr8, ppsb_pkg::OFS_OUT_BASE);
	assign bif.sw_idx = addr8[3:2];
	assign bif.sw_wdata = reg_wdata_i[7:0];

	ppsb_bank u_bank (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.b(bif.bank)
	);

	// Summary flags follow the per-byte flags with no delay.
	assign input_full_summary = &bif.in_full;
	assign output_empty_summary = &bif.out_empty;
	assign status_word = {input_full_summary, ovf_r, 2'b00, bif.in_full,
		output_empty_summary, unf_r, 2'b00, bif.out_empty};

	// ----------------------------------------------------------------
	// Control registers and sticky flags.
	// ----------------------------------------------------------------
	// Masks drop writes to unimplemented bits so they always read zero.
	always_comb begin
		pe_nxt = pe_r;
		pc_nxt = pc_r;
		cal_nxt = cal_r;
		mode_nxt = mode_r;
		ovf_nxt = ovf_r;
		unf_nxt = unf_r;
		irq_en_nxt = irq_en_r;
		irq_stat_nxt = irq_stat_r;
		if (reg_wr_i) begin
			if (hit(addr8, ppsb_pkg::OFS_PIN_ENABLE)) begin
				pe_nxt = reg_wdata_i & ppsb_pkg::PE_MASK;
			end
			if (hit(addr8, ppsb_pkg::OFS_PAD_CFG)) begin
				pc_nxt = reg_wdata_i & ppsb_pkg::PC_MASK;
			end
			if (hit(addr8, ppsb_pkg::OFS_CAL)) begin
				cal_nxt = reg_wdata_i & ppsb_pkg::CAL_MASK;
			end
			if (hit(addr8, ppsb_pkg::OFS_PORT_MODE)) begin
				mode_nxt = reg_wdata_i & ppsb_pkg::MODE_MASK;
			end
			if (hit(addr8, ppsb_pkg::OFS_BUF_STATUS)) begin
				// Only a zero clears; a one cannot set the flag.
				ovf_nxt = ovf_r & reg_wdata_i[ppsb_pkg::ST_INPUT_OVERFLOW];
				unf_nxt = unf_r & reg_wdata_i[ppsb_pkg::ST_OUTPUT_UNDERFLOW];
			end
			if (hit(addr8, ppsb_pkg::OFS_IRQ_ENABLE)) begin
				irq_en_nxt = reg_wdata_i[ppsb_pkg::IRQ_W-1:0];
			end
			if (hit(addr8, ppsb_pkg::OFS_IRQ_CLEAR)) begin
				irq_stat_nxt = irq_stat_r & ~reg_wdata_i[ppsb_pkg::IRQ_W-1:0];
			end
		end
		// Hardware sets come last so an event beats a clear in one cycle.
		if (bif.ovf_evt) begin
			ovf_nxt = 1'b1;
			irq_stat_nxt[ppsb_pkg::IRQ_OVF] = 1'b1;
		end
		if (bif.unf_evt) begin
			unf_nxt = 1'b1;
			irq_stat_nxt[ppsb_pkg::IRQ_UNF] = 1'b1;
		end
		// Buffer-three events only count in interrupt mode three.
		if (bif.last_evt && irq_mode == ppsb_pkg::PPSB_IRQ_LAST) begin
			irq_stat_nxt[ppsb_pkg::IRQ_LAST] = 1'b1;
		end
		if (bif.xfer_evt && irq_mode == ppsb_pkg::PPSB_IRQ_XFER) begin
			irq_stat_nxt[ppsb_pkg::IRQ_XFER] = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pe_r <= ppsb_pkg::PE_RST;
			pc_r <= ppsb_pkg::PC_RST;
			cal_r <= ppsb_pkg::CAL_RST;
			mode_r <= ppsb_pkg::MODE_RST;
			ovf_r <= 1'b0;
			unf_r <= 1'b0;
			irq_en_r <= 4'h0;
			irq_stat_r <= 4'h0;
		end else begin
			pe_r <= pe_nxt;
			pc_r <= pc_nxt;
			cal_r <= cal_nxt;
			mode_r <= mode_nxt;
			ovf_r <= ovf_nxt;
			unf_r <= unf_nxt;
			irq_en_r <= irq_en_nxt;
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read path.
	// ----------------------------------------------------------------
	// Data stands only in the cycle after the strobe; unmapped reads zero.
	always_comb begin
		rdata_nxt = 16'h0000;
		if (reg_rd_i) begin
			case (addr8)
				ppsb_pkg::OFS_PIN_ENABLE: rdata_nxt = pe_r;
				ppsb_pkg::OFS_BUF_STATUS: rdata_nxt = status_word;
				ppsb_pkg::OFS_PAD_CFG: rdata_nxt = pc_r;
				ppsb_pkg::OFS_CAL: rdata_nxt = cal_r;
				ppsb_pkg::OFS_PORT_MODE: rdata_nxt = mode_r;
				ppsb_pkg::OFS_IRQ_STATUS: rdata_nxt = {12'h000, irq_stat_r};
				ppsb_pkg::OFS_IRQ_ENABLE: rdata_nxt = {12'h000, irq_en_r};
				default: begin
					if (in_win(addr8, ppsb_pkg::OFS_IN_BASE)) begin
						rdata_nxt = {8'h00, bif.in_data[{addr8[3:2], 3'b000} +: 8]};
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pad routing and clock output.
	// ----------------------------------------------------------------
	// A port-owned pad is always driven; general I/O keeps its own enable.
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pe_r[i]) begin
				pad_out_nxt[i] = port_address_pins_i[i];
				pad_oe_n_nxt[i] = 1'b0;
			end else begin
				pad_out_nxt[i] = gpio_out_i[i];
				pad_oe_n_nxt[i] = gpio_oe_n_i[i];
			end
		end
		clk_out_nxt = pc_r[ppsb_pkg::PC_CLKSEL] ? rtc_second_i
			: rtc_alarm_i;
		clk_oe_n_nxt = ~cal_r[ppsb_pkg::CAL_CLKOE];
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdata_r <= 16'h0000;
			pad_out_r <= 16'h0000;
			pad_oe_n_r <= 16'hffff;
			clk_out_r <= 1'b0;
			clk_oe_n_r <= 1'b1;
		end else begin
			rdata_r <= rdata_nxt;
			pad_out_r <= pad_out_nxt;
			pad_oe_n_r <= pad_oe_n_nxt;
			clk_out_r <= clk_out_nxt;
			clk_oe_n_r <= clk_oe_n_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign ext_rdata_o = bif.ext_rdata;
	assign pad_out_o = pad_out_r;
	assign pad_oe_n_o = pad_oe_n_r;
	assign clock_out_o = clk_out_r;
	assign clock_out_oe_n_o = clk_oe_n_r;
	assign input_threshold_select_o = pc_r[ppsb_pkg::PC_TTL];
	assign irq_o = |(irq_stat_r & irq_en_r);

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	AST_CS_PAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		pe_r[ppsb_pkg::PE_CS_BIT] |=> !pad_oe_n_o[ppsb_pkg::PE_CS_BIT]
		&& pad_out_o[ppsb_pkg::PE_CS_BIT] == $past(port_address_pins_i[14]))
		else $error("pad 14 not routed to the port");
	AST_ADDR_PAD_GPIO: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		!pe_r[5] |=> pad_out_o[5] == $past(gpio_out_i[5])
		&& pad_oe_n_o[5] == $past(gpio_oe_n_i[5]))
		else $error("disabled address pad not general I/O");
	AST_LATCH_PAD: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		pe_r[1:0] == 2'b11 |=> pad_oe_n_o[1:0] == 2'b00)
		else $error("latch pads not driven");
	AST_IBF_READ: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		reg_rd_i && addr8 == ppsb_pkg::OFS_BUF_STATUS
		|=> reg_rdata_o[ppsb_pkg::ST_IBF] == &$past(bif.in_full))
		else $error("input-full summary wrong");
	AST_OBE_READ: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		reg_rd_i && addr8 == ppsb_pkg::OFS_BUF_STATUS
		|=> reg_rdata_o[ppsb_pkg::ST_OBE] == &$past(bif.out_empty)
		&& reg_rdata_o[13:12] == 2'b00 && reg_rdata_o[5:4] == 2'b00)
		else $error("output-empty summary or reserved bits wrong");
	AST_OVF_SET: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		bif.ovf_evt |=> ovf_r ##1 (ovf_r
		|| $past(reg_wr_i && addr8 == ppsb_pkg::OFS_BUF_STATUS
		&& !reg_wdata_i[ppsb_pkg::ST_INPUT_OVERFLOW])))
		else $error("overflow flag not held");
	AST_UNF_SET: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		ext_rd_i && bif.out_empty[ext_idx_i] |=> unf_r)
		else $error("underflow flag not set");
	AST_STICKY_CLEAR: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		$fell(ovf_r) |-> $past(reg_wr_i) && !$past(reg_wdata_i[14])
		&& $past(addr8) == ppsb_pkg::OFS_BUF_STATUS)
		else $error("overflow flag cleared without a zero write");
	AST_CLOCK_OUT: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		pc_r[ppsb_pkg::PC_CLKSEL] |=> clock_out_o == $past(rtc_second_i))
		else $error("seconds clock not selected");
	AST_CLOCK_OE: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		!cal_r[ppsb_pkg::CAL_CLKOE] |=> clock_out_oe_n_o)
		else $error("clock pin driven while disabled");
	AST_TTL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		reg_wr_i && addr8 == ppsb_pkg::OFS_PAD_CFG
		|=> input_threshold_select_o == $past(reg_wdata_i[0]))
		else $error("threshold select not taken");
	AST_PE_RESERVED: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		reg_rd_i && addr8 == ppsb_pkg::OFS_PIN_ENABLE
		|=> reg_rdata_o[15] == 1'b0 && reg_rdata_o[13:11] == 3'b000)
		else $error("reserved pin-enable bits read nonzero");
	AST_LAST_IRQ: assert property (@(posedge mclk_i)
		disable iff (sys_rst_i)
		bif.last_evt && irq_mode == ppsb_pkg::PPSB_IRQ_LAST
		&& irq_en_r[ppsb_pkg::IRQ_LAST] |=> irq_o)
		else $error("buffer-three interrupt missing");
endmodule : ppsb_top
`default_nettype wire

// ---- tb/ppsb_peer.sv ----
// Behavioural model of the external host on the peer byte link.
`timescale 1ns/1ps
`default_nettype none
module ppsb_peer (
	input wire logic mclk_i,
	output logic ext_wr_o,
	output logic ext_rd_o,
	output logic [1:0] ext_idx_o,
	output logic [7:0] ext_wdata_o,
	input wire logic [7:0] ext_rdata_i
);
	// Idle lines start quiet; strobes are never left floating.
	initial begin
		ext_wr_o = 1'b0;
		ext_rd_o = 1'b0;
		ext_idx_o = 2'h0;
		ext_wdata_o = 8'h00;
	end

	// One host cycle. The host may write a full byte or read an empty
	// one, exactly as a careless real host would.
	// Strobes drop low and the released index and data lines show the inverse, so stale values are never trusted.
	task automatic xfer(input logic w, input logic r, input logic [1:0] i,
			input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk_i);
		ext_wr_o <= w;
		ext_rd_o <= r;
		ext_idx_o <= i;
		ext_wdata_o <= d;
		@(posedge mclk_i);
		ext_wr_o <= 1'b0;
		ext_rd_o <= 1'b0;
		ext_idx_o <= ~i;
		ext_wdata_o <= ~d;
		#1;
		q = ext_rdata_i;
	endtask : xfer
endmodule : ppsb_peer
`default_nettype wire

// ---- tb/ppsb_tb_top.sv ----
// Self-checking testbench of the pin and buffer status block.
`timescale 1ns/1ps
`default_nettype none
module ppsb_tb_top;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic ext_wr_i;
	logic ext_rd_i;
	logic [1:0] ext_idx_i;
	logic [7:0] ext_wdata_i;
	logic [7:0] ext_rdata_o;
	logic [15:0] pins = 16'h0000;
	logic [15:0] gpio = 16'h0000;
	logic [15:0] gpio_oe_n = 16'hffff;
	logic [15:0] pad_out_o;
	logic [15:0] pad_oe_n_o;
	logic rtc_sec = 1'b0;
	logic rtc_alm = 1'b0;
	logic clock_out_o;
	logic clock_out_oe_n_o;
	logic ttl_o;
	logic irq_o;
	int errors = 0;
	int num_checks = 0;
	int seed_v;
	// Reference model state, updated as each request is issued.
	logic [15:0] pe = 16'h0000;
	logic [15:0] pc = 16'h0000;
	logic [15:0] cal = 16'h0000;
	logic [1:0] mode = 2'h0;
	logic [3:0] en = 4'h0;
	logic [3:0] m_irq = 4'h0;
	logic [3:0] m_full = 4'h0;
	logic [3:0] m_empty = 4'hf;
	logic m_ovf = 1'b0;
	logic m_unf = 1'b0;
	logic [7:0] m_in [4] = '{default: 8'h00};
	logic [7:0] m_out [4] = '{default: 8'h00};
	logic [7:0] m_last = 8'h00;

	ppsb_top u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.ext_wr_i(ext_wr_i), .ext_rd_i(ext_rd_i), .ext_idx_i(ext_idx_i),
		.ext_wdata_i(ext_wdata_i), .ext_rdata_o(ext_rdata_o),
		.port_address_pins_i(pins), .gpio_out_i(gpio),
		.gpio_oe_n_i(gpio_oe_n), .pad_out_o(pad_out_o),
		.pad_oe_n_o(pad_oe_n_o), .rtc_second_i(rtc_sec),
		.rtc_alarm_i(rtc_alm), .clock_out_o(clock_out_o),
		.clock_out_oe_n_o(clock_out_oe_n_o),
		.input_threshold_select_o(ttl_o), .irq_o(irq_o));
	ppsb_peer u_peer (.mclk_i(mclk_i), .ext_wr_o(ext_wr_i),
		.ext_rd_o(ext_rd_i), .ext_idx_o(ext_idx_i),
		.ext_wdata_o(ext_wdata_i), .ext_rdata_i(ext_rdata_o));

	// 125 MHz clock.
	initial begin
		forever #4 mclk_i = ~mclk_i;
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [15:0] mread(input logic [7:0] a);
		case (a)
			8'h00: return pe;
			8'h04: return {&m_full, m_ovf, 2'b00, m_full,
				&m_empty, m_unf, 2'b00, m_empty};
			8'h08: return pc;
			8'h0c: return cal;
			8'h10: return {1'b0, mode, 13'h0000};
			8'h20, 8'h24, 8'h28, 8'h2c: return {8'h00, m_in[a[3:2]]};
			8'h40: return {12'h000, m_irq};
			8'h44: return {12'h000, en};
			default: return 16'h0000;
		endcase
	endfunction : mread

	// Register read; reading an input byte empties it in the model.
	task automatic rc(input logic [7:0] a);
		logic [15:0] e;
		e = mread(a);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
		if (a[7:4] == 4'h2) m_full[a[3:2]] = 1'b0;
	endtask : rc

	// Register write; the model keeps only implemented bits.
	task automatic rw(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		if (a == 8'h00) pe = d & 16'h47ff;
		if (a == 8'h04) m_ovf = m_ovf & d[14];
		if (a == 8'h04) m_unf = m_unf & d[6];
		if (a == 8'h08) pc = d & 16'h0003;
		if (a == 8'h0c) cal = d & 16'h0400;
		if (a == 8'h10) mode = d[14:13];
		if (a[7:4] == 4'h3) m_out[a[3:2]] = d[7:0];
		if (a[7:4] == 4'h3) m_empty[a[3:2]] = 1'b0;
		if (a == 8'h44) en = d[3:0];
		if (a == 8'h48) m_irq = m_irq & ~d[3:0];
	endtask : rw

	// Peer access with random write data, then data and interrupt checks.
	task automatic px(input logic w, input logic r, input logic [1:0] i);
		logic [7:0] d;
		logic [7:0] q;
		d = 8'($urandom);
		// Overflow and underflow also raise their interrupt status bits.
		if (w && m_full[i]) begin
			m_ovf = 1'b1;
			m_irq[0] = 1'b1;
		end else if (w) begin
			m_in[i] = d;
		end
		if (w) m_full[i] = 1'b1;
		if (r && m_empty[i]) begin
			m_unf = 1'b1;
			m_irq[1] = 1'b1;
		end else if (r) begin
			m_last = m_out[i];
		end
		if (r) m_empty[i] = 1'b1;
		if (mode == 2'h1) m_irq[3] = 1'b1;
		if (mode == 2'h3 && i == 2'h3) m_irq[2] = 1'b1;
		u_peer.xfer(w, r, i, d, q);
		chk({8'h00, q}, {8'h00, m_last});
		chk({15'h0, irq_o}, {15'h0, |(m_irq & en)});
	endtask : px

	// Random pad-side inputs, then pad and clock pin outputs.
	task automatic pchk();
		@(posedge mclk_i);
		pins <= 16'($urandom);
		gpio <= 16'($urandom);
		gpio_oe_n <= 16'($urandom);
		rtc_sec <= 1'($urandom);
		rtc_alm <= 1'($urandom);
		repeat (2) @(posedge mclk_i);
		#1;
		chk(pad_out_o, (pins & pe) | (gpio & ~pe));
		chk(pad_oe_n_o, gpio_oe_n & ~pe);
		chk({15'h0, clock_out_o}, {15'h0, pc[1] ? rtc_sec : rtc_alm});
		chk({15'h0, clock_out_oe_n_o}, {15'h0, ~cal[10]});
		chk({15'h0, ttl_o}, {15'h0, pc[0]});
	endtask : pchk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	// Watchdog sized well beyond the few hundred cycles the tests need.
	initial begin
		repeat (30000) @(posedge mclk_i);
		errors++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		seed_v = $urandom(32);
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		for (int k = 0; k < 18; k++) rc(8'(4 * k));
		rc(8'h7c);
		$display("test reset values done");
		for (int k = 0; k < 8; k++) begin
			rw(8'h00, 16'($urandom));
			rw(8'h08, 16'($urandom));
			rw(8'h0c, 16'($urandom));
			pchk();
			rc(8'h00);
			rc(8'h08);
		end
		$display("test pads done");
		for (int k = 0; k < 4; k++) begin
			px(1'b1, 1'b0, 2'(k));
			rc(8'h04);
		end
		px(1'b1, 1'b0, 2'h2);
		rc(8'h04);
		rc(8'h40);
		rw(8'h04, 16'hffff);
		rc(8'h04);
		rw(8'h04, 16'h0000);
		rc(8'h04);
		for (int k = 0; k < 4; k++) begin
			rc(8'h20 + 8'(4 * k));
			rc(8'h04);
		end
		$display("test input buffers done");
		for (int k = 0; k < 4; k++) begin
			rw(8'h30 + 8'(4 * k), 16'($urandom));
			rc(8'h04);
		end
		for (int k = 0; k < 4; k++) begin
			px(1'b0, 1'b1, 2'(k));
			rc(8'h04);
		end
		px(1'b0, 1'b1, 2'h1);
		rc(8'h04);
		rc(8'h40);
		rw(8'h04, 16'hffbf);
		rc(8'h04);
		$display("test output buffers done");
		for (int m = 0; m < 4; m++) begin
			rw(8'h10, 16'(m) << 13);
			rw(8'h48, 16'hffff);
			rw(8'h44, 16'h000f);
			for (int k = 0; k < 4; k++) rw(8'h30 + 8'(4 * k), 16'($urandom));
			for (int k = 0; k < 4; k++) px(1'b0, 1'b1, 2'(k));
			rc(8'h40);
			rw(8'h44, 16'h0000);
			#1;
			chk({15'h0, irq_o}, 16'h0000);
			rc(8'h10);
		end
		$display("test interrupts done");
		end_sim();
	end
endmodule : ppsb_tb_top
`default_nettype wire
